// >>> bench/host_trigger_model.sv
// Host side model that strobes the watchdog trigger input
`timescale 1ns/1ps
`default_nettype none

module host_trigger_model (
  input wire logic clk_sys,
  input wire logic strobe,
  output var logic watchdog_trigger_in
);
  logic [2:0] low_cnt_r = 3'h0;

  // Falling edge then release; the line idles high as if pulled up
  always @(negedge clk_sys) begin
    if (strobe) begin
      low_cnt_r <= 3'h4;
    end else if (low_cnt_r != 3'h0) begin
      low_cnt_r <= low_cnt_r - 3'h1;
    end
  end
  assign watchdog_trigger_in = (low_cnt_r == 3'h0);
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int PU = 40;
  localparam int PER = 100;
  localparam int PUL = 10;
  logic clk_sys, reset_n, strobe, select_floating, transmitter_off;
  wire logic trig;
  logic watchdog_reset_out_n, watchdog_active, window_open;
  int fail_count, tests_run, cycles, n;

  windowed_watchdog #(.POWERUP_CYCLES(PU), .PERIOD_CYCLES(PER), .PULSE_CYCLES(PUL)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .watchdog_trigger_in(trig),
    .select_floating(select_floating), .transmitter_off(transmitter_off),
    .watchdog_reset_out_n(watchdog_reset_out_n), .watchdog_active(watchdog_active),
    .window_open(window_open));
  host_trigger_model host (.clk_sys(clk_sys), .strobe(strobe), .watchdog_trigger_in(trig));

  // ==========================================================================
  // Clock, timeout, reporting
  // ==========================================================================
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Whole run needs well under a thousand cycles; a hang is cut at 20000
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi);
    check({31'h0, (got >= lo && got <= hi)}, 32'h1);
  endtask

  // ==========================================================================
  // Helpers, all on the falling edge
  // ==========================================================================
  task automatic wait_for(input logic lvl, input int lim, output int k);
    k = 0;
    while (watchdog_reset_out_n !== lvl && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  task automatic do_reset();
    @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  // Non-blocking so the model's falling-edge process sees the old level, with no race
  task automatic pulse_strobe(input int gap);
    strobe <= 1'b1;
    @(negedge clk_sys);
    strobe <= 1'b0;
    repeat (gap) @(negedge clk_sys);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_powerup();
    do_reset();
    check({31'h0, watchdog_reset_out_n}, 32'h1);
    wait_for(1'b0, 200, n);
    check_range(n, PU - 6, PU + 2);
    wait_for(1'b1, 50, n);
    check(n, PUL);
    wait_for(1'b0, 200, n);
    check_range(n, PU - 1, PU + 1);
    $display("test powerup done");
  endtask
  task automatic t_window();
    do_reset();
    pulse_strobe(8);
    check({31'h0, window_open}, 32'h0);
    n = 0;
    while (window_open !== 1'b1 && n < PER) begin
      @(negedge clk_sys);
      n++;
    end
    check_range(n, PER / 2 - 12, PER / 2);
    pulse_strobe(6);
    check({31'h0, window_open}, 32'h0);
    wait_for(1'b0, PER / 2, n);
    check(n, PER / 2);
    $display("test window done");
  endtask
  task automatic t_early();
    do_reset();
    pulse_strobe(20);
    pulse_strobe(0);
    wait_for(1'b0, 10, n);
    check_range(n, 2, 5);
    wait_for(1'b1, 50, n);
    check(n, PUL);
    wait_for(1'b0, PER + 10, n);
    check_range(n, PER - 1, PER + 1);
    $display("test early done");
  endtask
  task automatic t_disable();
    select_floating = 1'b1;
    do_reset();
    wait_for(1'b0, 3 * PU, n);
    check(n, 3 * PU);
    check({31'h0, watchdog_active}, 32'h0);
    select_floating = 1'b0;
    transmitter_off = 1'b1;
    wait_for(1'b0, 3 * PU, n);
    check(n, 3 * PU);
    transmitter_off = 1'b0;
    wait_for(1'b0, 200, n);
    check_range(n, PU - 2, PU + 6);
    $display("test disable done");
  endtask

  initial begin
    reset_n = 1'b0;
    strobe = 1'b0;
    select_floating = 1'b0;
    transmitter_off = 1'b0;
    fail_count = 0;
    tests_run = 0;
    cycles = 0;
    t_powerup();
    t_window();
    t_early();
    t_disable();
    close_out();
  end
endmodule
`default_nettype wire

// >>> inc/wdog_pkg.sv
// Constants and types for the windowed watchdog reset block
`default_nettype none
package wdog_pkg;

  // ==========================================================================
  // Timebase
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned CNT_W = 32;

  // ==========================================================================
  // Interval formulas, times in microseconds
  // ==========================================================================
  localparam int unsigned POWERUP_US_PER_KOHM = 800;
  localparam int unsigned PERIOD_US_PER_KOHM = 175;
  localparam int unsigned PERIOD_OFFSET_US = 1200;
  localparam int unsigned RESET_PULSE_US = 150;
  localparam int unsigned RSEL_MIN_KOHM = 33;
  localparam int unsigned RSEL_MAX_KOHM = 680;
  localparam int unsigned RSEL_DEFAULT_KOHM = 33;
  localparam int unsigned PS_PER_US = 1000000;

  // Least time rounds up, never below one cycle
  function automatic int unsigned us_to_cycles_up(input longint unsigned us);
    longint unsigned c;
    c = (us * PS_PER_US + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c == 0) begin
      c = 1;
    end
    return int'(c);
  endfunction

  // ==========================================================================
  // Phases
  // ==========================================================================
  typedef enum logic [1:0] {
    PH_POWERUP,
    PH_NORMAL,
    PH_PULSE,
    PH_OFF
  } phase_t;

endpackage
`default_nettype wire

// >>> rtl/windowed_watchdog.sv
// Windowed watchdog that strobes an active-low reset on missing or early triggers
// Summary of operation
// - Period running out without a trigger drives the reset output low.
// - Normal triggers accepted only between half and full period after last trigger.
// - Floating select input disables the watchdog, reset output stays high.
// - After power-on, reset output high and the power-up interval starts, no window.
// - No trigger within power-up interval: pulse reset low, restart power-up interval.
// - First power-up trigger resets timer, ends power-up, enables windowed operation.
// - Power-up interval is 0.8 ms times select kilohms plus one.
// - Each reset pulse lasts about 150 us.
// - Trigger inside the open window restarts the period, reset output stays high.
// - Early trigger pulses reset low at once; next period starts on its rise.
// - Period expiry without trigger pulses reset low; next period starts on its rise.
// - Period is 0.175 ms per kilohm plus 1.2 ms, select 33 to 680 kilohms.
// - Watchdog disabled while the transmitter-off low-power state is active.
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog
  import wdog_pkg::*;
#(
  parameter int unsigned RSEL_KOHM = RSEL_DEFAULT_KOHM,
  // Long counts are parameters so a simulation can shorten them
  parameter int unsigned POWERUP_CYCLES =
    us_to_cycles_up(longint'(POWERUP_US_PER_KOHM) * (RSEL_KOHM + 1)),
  parameter int unsigned PERIOD_CYCLES =
    us_to_cycles_up(longint'(PERIOD_US_PER_KOHM) * RSEL_KOHM + PERIOD_OFFSET_US),
  parameter int unsigned PULSE_CYCLES = us_to_cycles_up(RESET_PULSE_US)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic watchdog_trigger_in,
  input wire logic select_floating,
  input wire logic transmitter_off,
  output logic watchdog_reset_out_n,
  output logic watchdog_active,
  output logic window_open
);

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic rst_meta_r;
  logic rst_sync_n_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // State
  // ==========================================================================
  localparam logic [CNT_W-1:0] POWERUP_LAST = CNT_W'(POWERUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] WINDOW_START = CNT_W'(PERIOD_CYCLES / 2);

  typedef struct packed {
    logic [2:0] trig_sync;
    logic [1:0] floating_sync;
    logic [1:0] txoff_sync;
    phase_t phase;
    logic after_powerup;
    logic [CNT_W-1:0] count;
    logic out_n;
    logic win;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  localparam state_t ST_RESET = '{
    trig_sync: 3'h7,
    floating_sync: 2'h0,
    txoff_sync: 2'h0,
    phase: PH_POWERUP,
    after_powerup: 1'b0,
    count: '0,
    out_n: 1'b1,
    win: 1'b0
  };

  logic trig_fall;
  logic disabled;

  // Stage 0 feeds only stage 1; edge detect looks at stages 1 and 2
  assign trig_fall = st_r.trig_sync[2] & ~st_r.trig_sync[1];
  assign disabled = st_r.floating_sync[1] | st_r.txoff_sync[1];

  always_comb begin
    st_nxt = st_r;
    st_nxt.trig_sync = {st_r.trig_sync[1:0], watchdog_trigger_in};
    st_nxt.floating_sync = {st_r.floating_sync[0], select_floating};
    st_nxt.txoff_sync = {st_r.txoff_sync[0], transmitter_off};
    st_nxt.count = st_r.count + CNT_W'(1);
    if (disabled) begin
      // Re-enabling starts again from the power-up phase
      st_nxt.phase = PH_OFF;
      st_nxt.count = '0;
      st_nxt.out_n = 1'b1;
      st_nxt.after_powerup = 1'b0;
    end else begin
      unique case (st_r.phase)
        PH_OFF: begin
          st_nxt.phase = PH_POWERUP;
          st_nxt.count = '0;
        end
        PH_POWERUP: begin
          if (trig_fall) begin
            st_nxt.phase = PH_NORMAL;
            st_nxt.count = '0;
          end else if (st_r.count >= POWERUP_LAST) begin
            st_nxt.phase = PH_PULSE;
            st_nxt.after_powerup = 1'b0;
            st_nxt.count = '0;
            st_nxt.out_n = 1'b0;
          end
        end
        PH_NORMAL: begin
          if (trig_fall && st_r.count >= WINDOW_START) begin
            st_nxt.count = '0;
          end else if (trig_fall) begin
            st_nxt.phase = PH_PULSE;
            st_nxt.after_powerup = 1'b1;
            st_nxt.count = '0;
            st_nxt.out_n = 1'b0;
          end else if (st_r.count >= PERIOD_LAST) begin
            st_nxt.phase = PH_PULSE;
            st_nxt.after_powerup = 1'b1;
            st_nxt.count = '0;
            st_nxt.out_n = 1'b0;
          end
        end
        PH_PULSE: begin
          if (st_r.count >= PULSE_LAST) begin
            // Next interval starts with the rising edge of the output
            st_nxt.phase = st_r.after_powerup ? PH_NORMAL : PH_POWERUP;
            st_nxt.count = '0;
            st_nxt.out_n = 1'b1;
          end
        end
      endcase
    end
    st_nxt.win = (st_nxt.phase == PH_NORMAL) && (st_nxt.count >= WINDOW_START);
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign watchdog_reset_out_n = st_r.out_n;
  assign watchdog_active = (st_r.phase != PH_OFF);
  assign window_open = st_r.win;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_early_trig;
    st_r.phase == PH_NORMAL && trig_fall && st_r.count < WINDOW_START && !disabled;
  endsequence

  sequence s_pulse_full;
    !watchdog_reset_out_n [*8];
  endsequence

  a_early_trig_reset: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    s_early_trig |=> !watchdog_reset_out_n)
    else $error("early trigger did not assert reset");

  a_window_trig_ok: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (st_r.phase == PH_NORMAL && trig_fall && window_open && !disabled)
      |=> watchdog_reset_out_n && st_r.count == '0)
    else $error("in-window trigger mishandled");

  a_expiry_reset: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (st_r.phase == PH_NORMAL && !trig_fall && st_r.count == PERIOD_LAST && !disabled)
      |=> !watchdog_reset_out_n)
    else $error("period expiry did not assert reset");

  a_powerup_expiry: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (st_r.phase == PH_POWERUP && !trig_fall && st_r.count == POWERUP_LAST && !disabled)
      |=> !watchdog_reset_out_n && !st_r.after_powerup)
    else $error("power-up expiry did not pulse reset");

  a_powerup_trig: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (st_r.phase == PH_POWERUP && trig_fall && !disabled)
      |=> st_r.phase == PH_NORMAL && st_r.count == '0 && watchdog_reset_out_n)
    else $error("power-up trigger did not enter windowed phase");

  a_disabled_high: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    disabled |=> watchdog_reset_out_n && !watchdog_active)
    else $error("disabled watchdog drove reset");

  a_pulse_width: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (st_r.phase == PH_PULSE && st_r.count == PULSE_LAST && !disabled)
      |=> watchdog_reset_out_n)
    else $error("reset pulse did not end on time");

  a_pulse_min: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r || disabled)
    $fell(watchdog_reset_out_n) && PULSE_CYCLES >= 8 |-> s_pulse_full)
    else $error("reset pulse too short");

  a_no_early_rise: assert property (@(posedge clk_sys) disable iff (!rst_sync_n_r)
    (st_r.phase == PH_NORMAL && st_r.count < WINDOW_START) |-> !window_open)
    else $error("window open too early");

endmodule

`default_nettype wire
